//--- pss_sram_port.sv
// pipelined synchronous sram device port with internal array
`timescale 1ns/1ps
`default_nettype none
`include "pss_cfg.svh"
module pss_sram_port #(
  parameter bit WIDE_ORG = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en_n,
  input wire logic [`PSS_ADDR_W-1:0] address_bus,
  input wire logic advance_or_load_n,
  input wire logic rw_n,
  input wire logic [`PSS_LANES-1:0] byte_lane_write_n,
  input wire logic chip_sel_n,
  input wire logic chip_sel_second_n,
  input wire logic chip_sel_high,
  input wire logic out_en_n,
  input wire logic snooze_request,
  input wire logic burst_order_select,
  input wire logic [`PSS_DATA_W-1:0] data_in,
  output logic [`PSS_DATA_W-1:0] data_out,
  output logic [`PSS_LANES-1:0] data_oe,
  output logic standby
);
  typedef pss_pkg::pss_cmd_t cmd_t;
  // pipeline: a load or advance at edge n fills stage 0, stage 1 at n+1,
  // and at n+2 the write data is taken or the read word registered;
  // data_oe stays combinational so the drivers follow the output enable
  // without waiting for a clock edge

  // next burst address from start bits and count
  function automatic logic [1:0] burst_lsb(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic lin);
    burst_lsb = lin ? 2'(start + cnt) : (start ^ cnt); // [RL22] [RL19]
  endfunction : burst_lsb

  logic [`PSS_DATA_W-1:0] mem [0:`PSS_DEPTH-1];
  logic run;
  logic [`PSS_ADDR_W-1:0] base_q, base_d;
  logic [1:0] cnt_q, cnt_d;
  logic sel_q, sel_d;
  logic wr_q, wr_d;
  cmd_t pipe_q [0:`PSS_PIPE-1];
  cmd_t pipe_d [0:`PSS_PIPE-1];
  cmd_t cur;
  logic [`PSS_DATA_W-1:0] rd_q, rd_d;
  logic rd_vld_q, rd_vld_d;
  logic [`PSS_DATA_W-1:0] lane_mask;
  logic [`PSS_IDX_W-1:0] widx;

  // clock gated by enable, frozen during snooze
  assign run = !clk_en_n && !snooze_request; // [RL14] [RL16]

  // burst and cycle bookkeeping
  always_comb begin
    base_d = base_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    wr_d = wr_q;
    if (!advance_or_load_n) begin
      base_d = address_bus; // [RL1] [RL13] [RL2]
      cnt_d = 2'h0;
      sel_d = !chip_sel_n && !chip_sel_second_n && chip_sel_high; // [RL8] [RL9]
      wr_d = !rw_n; // [RL21]
    end else begin
      cnt_d = 2'(cnt_q + 2'h1); // [RL11] [RL12]
    end
    cur.addr = {base_d[`PSS_ADDR_W-1:2],
                burst_lsb(base_d[1:0], cnt_d, !burst_order_select)}; // [RL20]
    cur.op = !sel_d ? pss_pkg::PSS_IDLE :
             (wr_d ? pss_pkg::PSS_WRITE : pss_pkg::PSS_READ);
    cur.lane_we = (sel_d && wr_d) ? ~byte_lane_write_n : 4'h0; // [RL4] [RL5]
    pipe_d[0] = cur; // [RL7]
    pipe_d[1] = pipe_q[0];
  end

  // registers advance only while running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_q <= '0;
      cnt_q <= 2'h0;
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      pipe_q[0] <= '0;
      pipe_q[1] <= '0;
    end else if (run) begin // [RL14]
      base_q <= base_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      wr_q <= wr_d;
      pipe_q[0] <= pipe_d[0];
      pipe_q[1] <= pipe_d[1];
    end
  end

  // per-lane write mask, parity bits only in wide organisation
  always_comb begin
    lane_mask = '0;
    for (int i = 0; i < `PSS_LANES; i++) begin
      lane_mask[i*8 +: 8] = {8{pipe_q[1].lane_we[i]}}; // [RL6] [RL3]
      lane_mask[32+i] = WIDE_ORG & pipe_q[1].lane_we[i]; // [RL17]
    end
    rd_d = rd_q;
    rd_vld_d = 1'b0;
    if (pipe_q[1].op == pss_pkg::PSS_READ) begin
      rd_d = mem[widx];
      if (!WIDE_ORG) rd_d[35:32] = 4'h0; // [RL17]
      rd_vld_d = 1'b1; // [RL23]
    end
  end
  assign widx = pipe_q[1].addr[`PSS_IDX_W-1:0];

  // array write at the late slot; contents survive snooze
  always_ff @(posedge clk) begin
    if (run && pipe_q[1].op == pss_pkg::PSS_WRITE) begin
      mem[widx] <= (mem[widx] & ~lane_mask) | (data_in & lane_mask); // [RL18] [RL15]
    end
  end

  // registered read data and status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= '0;
      rd_vld_q <= 1'b0;
      standby <= 1'b0;
    end else begin
      standby <= snooze_request; // [RL15]
      if (run) begin
        rd_q <= rd_d;
        rd_vld_q <= rd_vld_d;
      end
    end
  end

  // output path, drivers follow enable combinationally
  always_comb begin
    data_out = rd_q;
    data_oe = {`PSS_LANES{!out_en_n && rd_vld_q && !snooze_request}}; // [RL10]
  end

  // a selected load, then split by cycle type
  sequence s_sel_load;
    run && !advance_or_load_n && !chip_sel_n && !chip_sel_second_n
    && chip_sel_high;
  endsequence
  sequence s_wr_load;
    s_sel_load ##0 !rw_n;
  endsequence
  sequence s_rd_load;
    s_sel_load ##0 rw_n;
  endsequence

  // write data slot two running edges after the address
  property p_wr_slot;
    @(posedge clk) disable iff (!resetn)
    s_wr_load ##1 run[*2] |-> pipe_q[1].op == pss_pkg::PSS_WRITE;
  endproperty
  a_wr_slot: assert property (p_wr_slot) // [RL18]
    else $error("write slot not two edges late");
  property p_rd_slot;
    @(posedge clk) disable iff (!resetn)
    s_rd_load ##1 run[*3] |-> rd_vld_q;
  endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read late"); // [RL23]
  property p_freeze;
    @(posedge clk) disable iff (!resetn)
    !run |=> $stable(cnt_q) && $stable(base_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved"); // [RL14] [RL16]
  property p_load;
    @(posedge clk) disable iff (!resetn)
    run && !advance_or_load_n |=> base_q == $past(address_bus) && cnt_q == 2'h0;
  endproperty
  a_load: assert property (p_load) else $error("load missed"); // [RL13] [RL2]
  property p_adv;
    @(posedge clk) disable iff (!resetn)
    run && advance_or_load_n |=> cnt_q == 2'($past(cnt_q) + 2'h1) && $stable(wr_q);
  endproperty
  a_adv: assert property (p_adv) else $error("advance wrong"); // [RL11] [RL12]
  property p_sel;
    @(posedge clk) disable iff (!resetn)
    run && !advance_or_load_n && !chip_sel_high |=> !sel_q;
  endproperty
  a_sel: assert property (p_sel) else $error("bad select"); // [RL8] [RL9]
  property p_oe;
    @(posedge clk) disable iff (!resetn) out_en_n |-> data_oe == 4'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("drive without enable"); // [RL10]
  property p_rw;
    @(posedge clk) disable iff (!resetn)
    run && !advance_or_load_n |=> wr_q == !$past(rw_n);
  endproperty
  a_rw: assert property (p_rw) else $error("cycle type wrong"); // [RL21]

  // lane enables ride along with a selected write load
  property p_lane_we;
    @(posedge clk) disable iff (!resetn)
    s_wr_load |=> pipe_q[0].lane_we == ~$past(byte_lane_write_n);
  endproperty
  a_lane_we: assert property (p_lane_we) // [RL5]
    else $error("lane enables lost");

  // a lane whose enable is off keeps its old byte
  property p_lane_keep;
    @(posedge clk) disable iff (!resetn)
    run && pipe_q[1].op == pss_pkg::PSS_WRITE && !pipe_q[1].lane_we[1]
    |=> mem[$past(widx)][15:8] == $past(mem[widx][15:8]);
  endproperty
  a_lane_keep: assert property (p_lane_keep) // [RL3] [RL6]
    else $error("disabled lane written");

  // a lane whose enable is on takes its data byte
  property p_lane_take;
    @(posedge clk) disable iff (!resetn)
    run && pipe_q[1].op == pss_pkg::PSS_WRITE && pipe_q[1].lane_we[0]
    |=> mem[$past(widx)][7:0] == $past(data_in[7:0]);
  endproperty
  a_lane_take: assert property (p_lane_take) // [RL3] [RL6]
    else $error("enabled lane not written");

  // parity bit follows its lane in the wide organisation
  property p_par;
    @(posedge clk) disable iff (!resetn)
    run && pipe_q[1].op == pss_pkg::PSS_WRITE && pipe_q[1].lane_we[0]
    && WIDE_ORG |=> mem[$past(widx)][32] == $past(data_in[32]);
  endproperty
  a_par: assert property (p_par) // [RL17]
    else $error("parity bit not written");

  // any chip enable off at load gives an idle cycle
  property p_desel;
    @(posedge clk) disable iff (!resetn)
    run && !advance_or_load_n
    && (chip_sel_n || chip_sel_second_n || !chip_sel_high)
    |=> pipe_q[0].op == pss_pkg::PSS_IDLE;
  endproperty
  a_desel: assert property (p_desel) // [RL8] [RL9]
    else $error("deselected cycle active");

  // linear order adds the count to the start bits
  property p_lin;
    @(posedge clk) disable iff (!resetn)
    run && advance_or_load_n && !burst_order_select |=>
    pipe_q[0].addr[1:0] == 2'($past(base_q[1:0]) + $past(cnt_q) + 2'h1);
  endproperty
  a_lin: assert property (p_lin) // [RL19] [RL20] [RL22]
    else $error("linear burst address wrong");

  // interleaved order xors the count into the start bits
  property p_ilv;
    @(posedge clk) disable iff (!resetn)
    run && advance_or_load_n && burst_order_select |=>
    pipe_q[0].addr[1:0] == ($past(base_q[1:0]) ^ 2'($past(cnt_q) + 2'h1));
  endproperty
  a_ilv: assert property (p_ilv) // [RL19] [RL20] [RL22]
    else $error("interleaved burst address wrong");

  // a load passes the pin address straight into the pipeline
  property p_load_addr;
    @(posedge clk) disable iff (!resetn)
    run && !advance_or_load_n |=> pipe_q[0].addr == $past(address_bus);
  endproperty
  a_load_addr: assert property (p_load_addr) // [RL1] [RL7]
    else $error("loaded address wrong");

  // an advance keeps the upper address bits of the burst
  property p_upper;
    @(posedge clk) disable iff (!resetn)
    run && advance_or_load_n |=>
    pipe_q[0].addr[`PSS_ADDR_W-1:2] == base_q[`PSS_ADDR_W-1:2];
  endproperty
  a_upper: assert property (p_upper) // [RL1] [RL11]
    else $error("burst left its block");

  // snooze shows as standby one edge later
  property p_standby;
    @(posedge clk) disable iff (!resetn)
    snooze_request |=> standby;
  endproperty
  a_standby: assert property (p_standby) // [RL15]
    else $error("standby not reported");

  // no drive while snoozing
  property p_zz_quiet;
    @(posedge clk) disable iff (!resetn)
    snooze_request |-> data_oe == 4'h0;
  endproperty
  a_zz_quiet: assert property (p_zz_quiet) // [RL16]
    else $error("drive during snooze");

  // pipeline held while snoozing
  property p_zz_hold;
    @(posedge clk) disable iff (!resetn)
    snooze_request |=> $stable(pipe_q[0]) && $stable(pipe_q[1]);
  endproperty
  a_zz_hold: assert property (p_zz_hold) // [RL15] [RL16]
    else $error("pipeline moved in snooze");

  // read register held while stalled
  property p_cke_out;
    @(posedge clk) disable iff (!resetn)
    !run |=> $stable(rd_q) && $stable(rd_vld_q);
  endproperty
  a_cke_out: assert property (p_cke_out) // [RL14]
    else $error("read data moved in stall");

  // drivers on for a valid read with output enable low
  property p_oe_on;
    @(posedge clk) disable iff (!resetn)
    !out_en_n && rd_vld_q && !snooze_request |-> data_oe == 4'hf;
  endproperty
  a_oe_on: assert property (p_oe_on) // [RL10]
    else $error("drivers off for read");

  // an advance keeps the selection and base of the burst
  property p_sel_keep;
    @(posedge clk) disable iff (!resetn)
    run && advance_or_load_n |=> $stable(sel_q) && $stable(base_q);
  endproperty
  a_sel_keep: assert property (p_sel_keep) // [RL8] [RL12]
    else $error("advance changed selection");
endmodule : pss_sram_port
`default_nettype wire

//--- pss_cfg.svh
// constants for the pipelined synchronous sram port
// How it works
// RL1: address captured on rising clock edge
// RL2: low two address bits seed burst counter
// RL3: active-low byte enables gate written lanes
// RL4: controller gives byte enables with address
// RL5: byte enables kept for later data
// RL6: one enable per lane, in order
// RL7: all synchronous inputs registered each edge
// RL8: chip enables sampled only at load
// RL9: chip enables allow depth expansion
// RL10: output drivers follow output enable asynchronously
// RL11: advance high steps burst counter
// RL12: advance high ignores read/write select
// RL13: advance low loads new address
// RL14: clock enable high freezes all state; the standby register still follows snooze_request
// RL15: snooze enters standby, keeps contents
// RL16: snooze ignores all other inputs
// RL17: parity lanes only in wide organisation
// RL18: write data two edges after address
// RL19: burst wraps after fourth access
// RL20: burst order pin selects linear/interleaved
// RL21: read/write select fixes cycle at load
// RL22: interleave by xor, linear by add
// RL23: read data two edges after address
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_ADDR_W 18
`define PSS_LANES 4
`define PSS_LANE_W 9
`define PSS_DATA_W 36
`define PSS_DEPTH 256
`define PSS_IDX_W 8
`define PSS_PIPE 2
`endif

//--- pss_pkg.sv
// types for the pipelined synchronous sram port
`include "pss_cfg.svh"
package pss_pkg;
  typedef enum logic [1:0] {PSS_IDLE, PSS_READ, PSS_WRITE} pss_op_t;
  typedef struct packed {
    pss_op_t op;
    logic [`PSS_ADDR_W-1:0] addr;
    logic [`PSS_LANES-1:0] lane_we;
  } pss_cmd_t;
endpackage : pss_pkg

//--- pss_ctrl_model.sv
// controller model that drives the sram port pins
`timescale 1ns/1ps
`default_nettype none
`include "pss_cfg.svh"
module pss_ctrl_model (
  input wire logic clk,
  output logic clk_en_n,
  output logic [`PSS_ADDR_W-1:0] address_bus,
  output logic advance_or_load_n,
  output logic rw_n,
  output logic [`PSS_LANES-1:0] byte_lane_write_n,
  output logic chip_sel_n,
  output logic chip_sel_second_n,
  output logic chip_sel_high,
  output logic out_en_n,
  output logic snooze_request,
  output logic burst_order_select,
  output logic [`PSS_DATA_W-1:0] data_in
);
  // one pin cycle, changed just after the falling edge
  task automatic cyc(input logic ld_n, input logic [17:0] a,
    input logic rw, input logic [3:0] we, input logic sel,
    input logic [35:0] d);
    @(negedge clk);
    advance_or_load_n = ld_n;
    address_bus = a;
    rw_n = rw;
    byte_lane_write_n = we;
    chip_sel_high = sel;
    data_in = d;
  endtask : cyc
  // write: lane enables with address, data two edges later
  task automatic wr(input logic [17:0] a, input logic [3:0] we,
    input logic sel, input logic [35:0] d);
    cyc(1'b0, a, 1'b0, we, sel, ~d);
    cyc(1'b0, a, 1'b1, 4'hf, 1'b0, ~d);
    cyc(1'b0, a, 1'b1, 4'hf, 1'b0, d);
    cyc(1'b0, a, 1'b1, 4'hf, 1'b0, ~d);
  endtask : wr
  // static pins: clock enable, output enable, snooze, order, selects
  task automatic mode(input logic [5:0] m);
    {clk_en_n, out_en_n, snooze_request, burst_order_select, chip_sel_n,
      chip_sel_second_n} = m;
  endtask : mode
  // idle pin levels
  initial begin
    clk_en_n = 1'b0;
    chip_sel_n = 1'b0;
    chip_sel_second_n = 1'b0;
    out_en_n = 1'b0;
    snooze_request = 1'b0;
    burst_order_select = 1'b0;
    advance_or_load_n = 1'b0;
    address_bus = 18'h0;
    rw_n = 1'b1;
    byte_lane_write_n = 4'hf;
    chip_sel_high = 1'b0;
    data_in = 36'h0;
  end
endmodule : pss_ctrl_model
`default_nettype wire

//--- tb_pss_sram_port.sv
// self-checking testbench for the sram port
`timescale 1ns/1ps
`default_nettype none
`include "pss_cfg.svh"
module tb_pss_sram_port;
  logic clk = 1'b0, resetn = 1'b0, clk_en_n, advance_or_load_n, rw_n;
  logic chip_sel_n, chip_sel_second_n, chip_sel_high, out_en_n;
  logic snooze_request, burst_order_select, standby;
  logic [17:0] address_bus;
  logic [3:0] byte_lane_write_n, data_oe;
  logic [35:0] data_in, data_out;
  int failures = 0, total_checks = 0;
  pss_sram_port dut (.clk, .resetn, .clk_en_n, .address_bus,
    .advance_or_load_n, .rw_n, .byte_lane_write_n, .chip_sel_n,
    .chip_sel_second_n, .chip_sel_high, .out_en_n, .snooze_request,
    .burst_order_select, .data_in, .data_out, .data_oe, .standby);
  pss_ctrl_model ctl (.clk, .clk_en_n, .address_bus, .advance_or_load_n,
    .rw_n, .byte_lane_write_n, .chip_sel_n, .chip_sel_second_n,
    .chip_sel_high, .out_en_n, .snooze_request, .burst_order_select,
    .data_in);
  always #20 clk = ~clk;
  // compare and count
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // read: load, then pipeline depth plus one cycles to the data slot
  task automatic rd(input logic [17:0] a, input logic [35:0] exp);
    ctl.cyc(1'b0, a, 1'b1, 4'hf, 1'b1, 36'h0);
    repeat (`PSS_PIPE + 1) ctl.cyc(1'b0, a, 1'b1, 4'hf, 1'b0, 36'h0);
    chk({32'h0, data_oe}, out_en_n ? 36'h0 : 36'hf);
    if (!out_en_n) chk(data_out, exp);
  endtask : rd
  // full word written and read back
  task automatic t_full;
    ctl.wr(18'h5, 4'h0, 1'b1, 36'hf_a5c3_9618);
    rd(18'h5, 36'hf_a5c3_9618);
  endtask : t_full
  // only lanes 0 and 2 take new data
  task automatic t_lanes;
    ctl.wr(18'h5, 4'ha, 1'b1, 36'h0_1111_2222);
    rd(18'h5, 36'ha_a511_9622);
  endtask : t_lanes
  // deselected write leaves the word unchanged
  task automatic t_desel;
    ctl.mode(6'h02);
    ctl.wr(18'h5, 4'h0, 1'b1, 36'h0);
    ctl.mode(6'h01);
    ctl.wr(18'h5, 4'h0, 1'b1, 36'h0);
    ctl.mode(6'h00);
    ctl.wr(18'h5, 4'h0, 1'b0, 36'h0);
    rd(18'h5, 36'ha_a511_9622);
  endtask : t_desel
  // output enable high keeps drivers off
  task automatic t_oe;
    ctl.mode(6'h10);
    rd(18'h5, 36'h0);
    ctl.mode(6'h00);
  endtask : t_oe
  // linear burst write from 9, interleaved burst read back
  task automatic t_burst;
    logic [35:0] exp [4];
    exp = '{36'h1_1000_0001, 36'h8_8000_0008, 36'h4_4000_0004,
      36'h2_2000_0002};
    ctl.cyc(1'b0, 18'h9, 1'b0, 4'h0, 1'b1, 36'h0);
    ctl.cyc(1'b1, 18'h0, 1'b1, 4'h0, 1'b1, 36'h0);
    ctl.cyc(1'b1, 18'h0, 1'b1, 4'h0, 1'b1, 36'h1_1000_0001);
    ctl.cyc(1'b1, 18'h0, 1'b1, 4'h0, 1'b1, 36'h2_2000_0002);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h4_4000_0004);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h8_8000_0008);
    ctl.mode(6'h04);
    ctl.cyc(1'b0, 18'h9, 1'b1, 4'hf, 1'b1, 36'h0);
    repeat (3) ctl.cyc(1'b1, 18'h0, 1'b0, 4'hf, 1'b1, 36'h0);
    for (int k = 0; k < 4; k++) begin
      chk({32'h0, data_oe}, 36'hf);
      chk(data_out, exp[k]);
      ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h0);
    end
    ctl.mode(6'h00);
  endtask : t_burst
  // clock enable high for one edge delays the read by one cycle
  task automatic t_freeze;
    ctl.cyc(1'b0, 18'h9, 1'b1, 4'hf, 1'b1, 36'h0);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h0);
    ctl.mode(6'h20);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h0);
    ctl.mode(6'h00);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h0);
    chk({32'h0, data_oe}, 36'h0);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h0);
    chk(data_out, 36'h1_1000_0001);
  endtask : t_freeze
  // snooze ignores a write, keeps the array and reports standby
  task automatic t_snooze;
    ctl.mode(6'h08);
    ctl.wr(18'h5, 4'h0, 1'b1, 36'h0);
    chk({35'h0, standby}, 36'h1);
    chk({32'h0, data_oe}, 36'h0);
    ctl.mode(6'h00);
    ctl.cyc(1'b0, 18'h0, 1'b1, 4'hf, 1'b0, 36'h0);
    chk({35'h0, standby}, 36'h0);
    rd(18'h5, 36'ha_a511_9622);
  endtask : t_snooze
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    t_full();
    t_lanes();
    t_desel();
    t_oe();
    t_burst();
    t_freeze();
    t_snooze();
    close_out();
  end
  // hang guard
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule : tb_pss_sram_port
`default_nettype wire
